// *** bench/rx_far_side.sv ***
// Serial engine model: frame starts and received data sets.
// Assumes the bench calls its tasks; one clock, no reset of its own.
`timescale 1ns/10ps
`default_nettype none
module rx_far_side
(
    input  wire logic                      clk,
    output logic                           sofPulse,
    output logic                           setValid,
    output logic [rx_flag_pkg::CNT_W-1:0]  setBytes
);
    import rx_flag_pkg::*;
    initial begin
        sofPulse = 1'b0;
        setValid = 1'b0;
        setBytes = '0;
    end
    // Count is inverted once invalid, so no stale value looks valid
    task automatic sendSet(input logic [CNT_W-1:0] n);
        @(posedge clk);
        setValid <= 1'b1;
        setBytes <= n;
        @(posedge clk);
        setValid <= 1'b0;
        setBytes <= ~n;
    endtask
    task automatic frame;
        @(posedge clk);
        sofPulse <= 1'b1;
        @(posedge clk);
        sofPulse <= 1'b0;
    endtask
endmodule // rx_far_side
`default_nettype wire

// *** bench/rx_fifo_flush_status_flags_tb.sv ***
// Bench for the receive flag block: AHB-Lite firmware side, engine model.
// Assumes hreadyout is the only slave's hready.
`timescale 1ns/10ps
`default_nettype none
module rx_fifo_flush_status_flags_tb;
    import rx_flag_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0] htrans = HT_IDLE;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = '0, hrdata, rd;
    logic hreadyout, hresp, irq, sofPulse, setValid;
    logic [CNT_W-1:0] setBytes;
    int errors = 0, checks = 0;
    always #2.5 clk = ~clk;
    rx_fifo_flush_status_flags i_rx_fifo_flush_status_flags (.clk(clk), .sys_rst(sys_rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sofPulse(sofPulse), .setValid(setValid), .setBytes(setBytes), .irq(irq));
    rx_far_side i_rx_far_side (.clk(clk), .sofPulse(sofPulse), .setValid(setValid),
        .setBytes(setBytes));
    task automatic complete_run;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic waitRdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            complete_run;
        end
    endtask
    // One single word transfer, address phase then data phase
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HT_NONSEQ;
        hwrite <= w;
        haddr <= a;
        waitRdy();
        htrans <= HT_IDLE;
        hsel <= 1'b0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        cmp("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic chkRd(input string what, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        cmp(what, e, rd);
    endtask
    task automatic irqIs(input logic e);
        repeat (3) @(posedge clk);
        cmp("irq", {31'h0, e}, {31'h0, irq});
    endtask
    task automatic chkReset;
        chkRd("flags", OFF_FLAGS, 32'h08);
        chkRd("size", OFF_SIZE, 32'h40);
        chkRd("unmapped", 8'h1C, 32'h0);
    endtask
    task automatic chkNonIso;
        xfer(1'b1, OFF_CTRL, 32'h1);
        i_rx_far_side.sendSet(11'h040);
        chkRd("flags", OFF_FLAGS, 32'h44);
        xfer(1'b0, OFF_DATA, 32'h0);
        chkRd("flags", OFF_FLAGS, 32'h40);
        xfer(1'b1, OFF_CTRL, 32'h5);
        chkRd("flags", OFF_FLAGS, 32'h08);
    endtask
    task automatic chkFlush;
        xfer(1'b1, OFF_IRQEN, 32'h1);
        xfer(1'b1, OFF_CTRL, 32'h3);
        i_rx_far_side.sendSet(11'h004);
        chkRd("flags", OFF_FLAGS, 32'h08);
        i_rx_far_side.frame();
        chkRd("flags", OFF_FLAGS, 32'h40);
        i_rx_far_side.frame();
        chkRd("flags", OFF_FLAGS, 32'h18);
        chkRd("irqst", OFF_IRQST, 32'h3);
        irqIs(1'b1);
        xfer(1'b1, OFF_IRQEN, 32'h0);
        irqIs(1'b0);
        xfer(1'b1, OFF_CTRL, 32'h7);
        chkRd("flags", OFF_FLAGS, 32'h08);
        xfer(1'b1, OFF_IRQEN, 32'h1);
        irqIs(1'b1);
        xfer(1'b1, OFF_IRQCL, 32'h1);
        irqIs(1'b0);
        chkRd("irqst", OFF_IRQST, 32'h2);
    endtask
    // Read finished inside its frame: no drop at the next frame start
    task automatic chkOnTime;
        i_rx_far_side.sendSet(11'h004);
        i_rx_far_side.frame();
        xfer(1'b1, OFF_CTRL, 32'h7);
        i_rx_far_side.frame();
        chkRd("flags", OFF_FLAGS, 32'h08);
    endtask
    task automatic chkNoFeat;
        xfer(1'b1, OFF_CTRL, 32'h2);
        i_rx_far_side.sendSet(11'h004);
        i_rx_far_side.frame();
        i_rx_far_side.frame();
        xfer(1'b0, OFF_FLAGS, 32'h0);
        cmp("flush", 32'h0, rd & 32'h30);
        cmp("flags", 32'h40, rd);
        xfer(1'b1, OFF_CTRL, 32'h6);
    endtask
    // Late read with a one-byte set behind it: flushed, and data reads blocked
    task automatic chkBlocked;
        xfer(1'b1, OFF_SIZE, 32'h1);
        chkRd("size", OFF_SIZE, 32'h1);
        xfer(1'b1, OFF_CTRL, 32'h3);
        i_rx_far_side.sendSet(11'h004);
        i_rx_far_side.frame();
        i_rx_far_side.sendSet(11'h001);
        i_rx_far_side.frame();
        chkRd("flags", OFF_FLAGS, 32'h54);
        xfer(1'b0, OFF_DATA, 32'h0);
        chkRd("flags", OFF_FLAGS, 32'h54);
        xfer(1'b1, OFF_CTRL, 32'h7);
        chkRd("flags", OFF_FLAGS, 32'h08);
        chkRd("ctrl", OFF_CTRL, 32'h3);
        xfer(1'b1, OFF_IRQEN, 32'h2);
        chkRd("irqen", OFF_IRQEN, 32'h2);
        irqIs(1'b1);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        chkReset();
        chkNonIso();
        chkFlush();
        chkOnTime();
        chkNoFeat();
        chkBlocked();
        complete_run();
    end
endmodule // rx_fifo_flush_status_flags_tb
`default_nettype wire

// *** verilog/rx_fifo_flush_status_flags.sv ***
// Receive FIFO status flags: index, flush, empty and full, with AHB-Lite registers.
// Assumes the serial engine reports each received data set as a one-cycle pulse with its byte count.
//
// Operation
// - Bit 5 reads zero; writes ignored.
// - Flush flag only when feature enabled.
// - Flush updated at frame start, isochronous only.
// - Index increments on set; isochronous waits frame.
// - Unread isochronous set dropped at frame start, only with feature enabled.
// - Flush blocks effect of data port reads.
// - Read complete clears the flush flag.
// - Empty flag when current set holds nothing.
// - Full flag when set equals FIFO size.
// - Empty and full track live state.
// - Firmware changes immediate, isochronous USB changes at frame.
`timescale 1ns/10ps
`default_nettype none
module rx_fifo_flush_status_flags
(
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           hsel,
    input  wire logic [rx_flag_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [31:0]                    hwdata,
    input  wire logic                           hready,
    output logic [31:0]                         hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic                           sofPulse,
    input  wire logic                           setValid,
    input  wire logic [rx_flag_pkg::CNT_W-1:0]  setBytes,
    output logic                                irq
);
    import rx_flag_pkg::*;

    logic               featEn_q;
    logic               isoMode_q;
    logic [CNT_W-1:0]   fifoSize_q;
    logic [1:0]         setIdx_q;
    logic               pendSet_q;
    logic [CNT_W-1:0]   pendBytes_q;
    logic [CNT_W-1:0]   curBytes_q;
    logic [CNT_W-1:0]   nextBytes_q;
    logic               flush_q;
    logic [IRQ_W-1:0]   irqSt_q;
    logic [IRQ_W-1:0]   irqEn_q;
    logic               dphWrite_q;
    logic               dphRead_q;
    logic [ADDR_W-1:0]  dphAddr_q;

    function automatic logic [1:0] idxStep(input logic [1:0] v, input logic up, input logic dn);
        logic [1:0] r;
        r = v;
        if (up && !dn && v != IDX_MAX)
            r = v + 2'h1;
        else if (dn && !up && v != 2'h0)
            r = v - 2'h1;
        return r;
    endfunction

    // Bus address phase
    logic addrValid;
    assign addrValid = hsel && hready && htrans[1];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dphWrite_q <= 1'b0;
            dphRead_q  <= 1'b0;
            dphAddr_q  <= '0;
        end else if (hready) begin
            dphWrite_q <= addrValid && hwrite;
            dphRead_q  <= addrValid && !hwrite;
            dphAddr_q  <= haddr;
        end
    end

    // Zero wait states; response is always OKAY
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    logic wrCtrl, wrSize, wrIrqEn, wrIrqCl, rdData, readDone;
    assign wrCtrl   = dphWrite_q && dphAddr_q == OFF_CTRL;
    assign wrSize   = dphWrite_q && dphAddr_q == OFF_SIZE;
    assign wrIrqEn  = dphWrite_q && dphAddr_q == OFF_IRQEN;
    assign wrIrqCl  = dphWrite_q && dphAddr_q == OFF_IRQCL;
    assign rdData   = dphRead_q && dphAddr_q == OFF_DATA;
    assign readDone = wrCtrl && hwdata[BIT_RDDONE];

    // Read data staged in the address phase so hrdata is a flop
    logic [7:0]  flagByte;
    logic [31:0] rdMux;
    always_comb begin
        flagByte = 8'h00;
        flagByte[BIT_IDX_LO +: 2] = setIdx_q;
        flagByte[BIT_RSVD]        = 1'b0;
        flagByte[BIT_FLUSH]       = flush_q & featEn_q;
        flagByte[BIT_EMPTY]       = curBytes_q == '0;
        flagByte[BIT_FULL]        = curBytes_q == fifoSize_q;
        rdMux = WORD_ZERO;
        case (haddr)
            OFF_FLAGS: rdMux[7:0] = flagByte;
            OFF_CTRL:  rdMux[1:0] = {isoMode_q, featEn_q};
            OFF_SIZE:  rdMux[CNT_W-1:0] = fifoSize_q;
            OFF_IRQST: rdMux[IRQ_W-1:0] = irqSt_q;
            OFF_IRQEN: rdMux[IRQ_W-1:0] = irqEn_q;
            default:   rdMux = WORD_ZERO;
        endcase
    end

    // Captured at the address edge: a read right behind a write to the
    // same register returns the value from before that write
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            hrdata <= WORD_ZERO;
        else if (addrValid && !hwrite)
            hrdata <= rdMux;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            featEn_q   <= 1'b0;
            isoMode_q  <= 1'b0;
            fifoSize_q <= SIZE_RESET;
            irqEn_q    <= '0;
        end else begin
            if (wrCtrl) begin
                featEn_q  <= hwdata[BIT_FEAT];
                isoMode_q <= hwdata[BIT_ISO];
            end
            if (wrSize)
                fifoSize_q <= hwdata[CNT_W-1:0];
            if (wrIrqEn)
                irqEn_q <= hwdata[IRQ_W-1:0];
        end
    end

    // Flush decision at frame start
    logic isoFlush, isoCommit, usbInc, fwDec;
    assign isoFlush  = isoMode_q && featEn_q && sofPulse && setIdx_q != 2'h0 && !readDone;
    assign isoCommit = isoMode_q && sofPulse && pendSet_q;
    assign usbInc    = isoMode_q ? isoCommit : setValid;
    assign fwDec     = readDone || isoFlush;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pendSet_q   <= 1'b0;
            pendBytes_q <= '0;
        end else if (isoMode_q && setValid) begin
            pendSet_q   <= 1'b1;
            pendBytes_q <= setBytes;
        end else if (isoCommit || !isoMode_q) begin
            pendSet_q   <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            setIdx_q <= 2'h0;
        else
            setIdx_q <= idxStep(setIdx_q, usbInc, fwDec);
    end

    // Byte counts of the set being read and the one queued behind it
    // Reads gated on the visible flush so a late read cannot eat a new set
    logic [CNT_W-1:0] incBytes;
    assign incBytes = isoMode_q ? pendBytes_q : setBytes;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            curBytes_q  <= '0;
            nextBytes_q <= '0;
        end else begin
            if (fwDec) begin
                curBytes_q <= (usbInc && setIdx_q == 2'h1) ? incBytes :
                              (setIdx_q == IDX_MAX ? nextBytes_q : '0);
                if (usbInc && setIdx_q == IDX_MAX)
                    nextBytes_q <= incBytes;
            end else if (usbInc) begin
                if (setIdx_q == 2'h0)
                    curBytes_q <= incBytes;
                else if (setIdx_q == 2'h1)
                    nextBytes_q <= incBytes;
            end else if (rdData && !(flush_q && featEn_q) && curBytes_q != '0) begin
                curBytes_q <= curBytes_q - 11'h001;
            end
        end
    end

    // A read complete in the frame-start cycle blocks the set, so the clear wins
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            flush_q <= 1'b0;
        else if (isoFlush)
            flush_q <= 1'b1;
        else if (readDone)
            flush_q <= 1'b0;
    end

    logic [IRQ_W-1:0] irqSet;
    assign irqSet = {usbInc, isoFlush};

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            irqSt_q <= '0;
        else
            irqSt_q <= irqSet | (irqSt_q & ~(wrIrqCl ? hwdata[IRQ_W-1:0] : '0));
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst)
            irq <= 1'b0;
        else
            irq <= |((irqSet | (irqSt_q & ~(wrIrqCl ? hwdata[IRQ_W-1:0] : '0))) & irqEn_q);
    end

    a_flush_sets: assert property (@(posedge clk) disable iff (sys_rst)
        isoFlush |=> flush_q && setIdx_q == idxStep($past(setIdx_q), $past(usbInc), 1'b1))
        else $error("flush did not set flag and drop set");

    a_flush_clears: assert property (@(posedge clk) disable iff (sys_rst)
        readDone && !isoFlush |=> !flush_q)
        else $error("read complete did not clear flush");

    a_iso_defer: assert property (@(posedge clk) disable iff (sys_rst)
        isoMode_q && !sofPulse && !readDone |=> setIdx_q == $past(setIdx_q))
        else $error("iso index moved between frames");

    a_flush_gate: assert property (@(posedge clk) disable iff (sys_rst)
        addrValid && !hwrite && haddr == OFF_FLAGS && !featEn_q |=> !hrdata[BIT_FLUSH])
        else $error("flush visible without feature");

    a_reads_blocked: assert property (@(posedge clk) disable iff (sys_rst)
        rdData && flush_q && featEn_q && !usbInc && !fwDec |=> $stable(curBytes_q))
        else $error("read advanced while flushed");

    a_rsvd_zero: assert property (@(posedge clk) disable iff (sys_rst)
        $past(addrValid && !hwrite && haddr == OFF_FLAGS) |-> !hrdata[BIT_RSVD])
        else $error("reserved bit read as one");

    a_empty_live: assert property (@(posedge clk) disable iff (sys_rst)
        addrValid && !hwrite && haddr == OFF_FLAGS |=> hrdata[BIT_EMPTY] == ($past(curBytes_q) == '0))
        else $error("empty flag stale");

    a_full_live: assert property (@(posedge clk) disable iff (sys_rst)
        addrValid && !hwrite && haddr == OFF_FLAGS
        |=> hrdata[BIT_FULL] == ($past(curBytes_q) == $past(fifoSize_q)))
        else $error("full flag stale");

    a_no_iso_flush: assert property (@(posedge clk) disable iff (sys_rst)
        !isoMode_q && !flush_q |=> !flush_q)
        else $error("flush outside isochronous mode");

    // Index movement, flush cause, pending set, byte count, interrupt and bus answer
    a_flush_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(flush_q) |-> $past(sofPulse && isoMode_q && featEn_q))
        else $error("flush set without iso frame start");

    a_idx_bounded: assert property (@(posedge clk) disable iff (sys_rst)
        setIdx_q <= IDX_MAX)
        else $error("index above dual set limit");

    a_noniso_inc: assert property (@(posedge clk) disable iff (sys_rst)
        !isoMode_q && setValid && !readDone && setIdx_q != IDX_MAX |=> setIdx_q == $past(setIdx_q) + 2'h1)
        else $error("non-iso set did not raise index");

    a_hold_idle: assert property (@(posedge clk) disable iff (sys_rst)
        !dphWrite_q && !setValid && !sofPulse |=> $stable(setIdx_q))
        else $error("index moved with no event");

    a_pend_cleared: assert property (@(posedge clk) disable iff (sys_rst)
        isoCommit && !setValid |=> !pendSet_q)
        else $error("committed set still pending");

    a_iso_commit: assert property (@(posedge clk) disable iff (sys_rst)
        isoCommit && !fwDec && setIdx_q != IDX_MAX |=> setIdx_q == $past(setIdx_q) + 2'h1)
        else $error("iso set not committed at frame start");

    a_fw_dec: assert property (@(posedge clk) disable iff (sys_rst)
        readDone && !usbInc && setIdx_q != 2'h0 |=> setIdx_q == $past(setIdx_q) - 2'h1)
        else $error("read complete did not lower index at once");

    a_empty_idle: assert property (@(posedge clk) disable iff (sys_rst)
        setIdx_q == 2'h0 |-> curBytes_q == '0)
        else $error("bytes held with no set");

    a_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
        irq == |(irqSt_q & $past(irqEn_q)))
        else $error("interrupt level disagrees with status");

    a_bus_okay: assert property (@(posedge clk) disable iff (sys_rst)
        hreadyout && !hresp)
        else $error("bus answer not ready and okay");
endmodule // rx_fifo_flush_status_flags
`default_nettype wire

// *** verilog/rx_flag_pkg.sv ***
// Package for the receive FIFO status flag block.
// Assumes a single 200 MHz clock domain and an AHB-Lite register slave.
package rx_flag_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned CNT_W  = 11;

    // Register byte offsets
    localparam logic [7:0] OFF_FLAGS = 8'h00;
    localparam logic [7:0] OFF_CTRL  = 8'h04;
    localparam logic [7:0] OFF_SIZE  = 8'h08;
    localparam logic [7:0] OFF_IRQST = 8'h0C;
    localparam logic [7:0] OFF_IRQEN = 8'h10;
    localparam logic [7:0] OFF_IRQCL = 8'h14;
    localparam logic [7:0] OFF_DATA  = 8'h18;

    // Flag register layout
    localparam int unsigned BIT_IDX_LO = 6;
    localparam int unsigned BIT_RSVD   = 5;
    localparam int unsigned BIT_FLUSH  = 4;
    localparam int unsigned BIT_EMPTY  = 3;
    localparam int unsigned BIT_FULL   = 2;

    // Control register layout
    localparam int unsigned BIT_FEAT     = 0;
    localparam int unsigned BIT_ISO      = 1;
    localparam int unsigned BIT_RDDONE   = 2;

    // Interrupt status layout
    localparam int unsigned IRQ_W        = 2;
    localparam int unsigned IRQ_FLUSH    = 0;
    localparam int unsigned IRQ_ARRIVE   = 1;

    localparam logic [1:0]       IDX_MAX     = 2'h2;
    localparam logic [CNT_W-1:0] SIZE_RESET  = 11'h040;
    localparam logic [31:0]      WORD_ZERO   = 32'h0000_0000;

    typedef enum logic [1:0] {
        HT_IDLE   = 2'b00,
        HT_BUSY   = 2'b01,
        HT_NONSEQ = 2'b10,
        HT_SEQ    = 2'b11
    } htrans_t;
endpackage
